/* src/dch_regs.svh */
// Register offsets, field positions and reset values of the cut handshake
`ifndef DCH_REGS_SVH
`define DCH_REGS_SVH

// Register byte offsets
`define DCH_OFF_CTRL 8'h00
`define DCH_OFF_STATUS 8'h04
`define DCH_OFF_IRQ_STAT 8'h08
`define DCH_OFF_IRQ_MASK 8'h0c
`define DCH_OFF_PF_TIME 8'h10

// Control fields
`define DCH_CTRL_DLY_OUT 0
`define DCH_CTRL_DLY_OE 1

// Event bits, shared by status and mask
`define DCH_EV_W 5
`define DCH_EV_XFER 0
`define DCH_EV_PIERCE 1
`define DCH_EV_FAULT 2
`define DCH_EV_EN_LOST 3
`define DCH_EV_READY 4

// Preflow time in clock cycles
`define DCH_PF_W 16
`define DCH_PF_TIME_RST 16'h0032
`define DCH_PF_ONE 16'h0001

// Status register fields
`define DCH_ST_STATE_LSB 8

`endif

/* src/dch_pkg.sv */
// Types of the discrete cut handshake
package dch_pkg;
    typedef enum logic [2:0] {
        ST_OFF = 3'b000,
        ST_READY = 3'b001,
        ST_PREFLOW = 3'b010,
        ST_FIRE = 3'b011,
        ST_CUT = 3'b100
    } dch_state_e;

    typedef struct packed {
        logic en_s1;
        logic en_s2;
        logic start_s1;
        logic start_s2;
        logic delay_s1;
        logic delay_s2;
        logic hold_s1;
        logic hold_s2;
        dch_state_e state;
        logic [15:0] pf_cnt;
        logic [15:0] pf_time;
        logic power;
        logic shield;
        logic xfer;
        logic pierce;
        logic fault;
        logic contact;
        logic ready;
        logic dly_out;
        logic dly_oe;
        logic [4:0] irq_stat;
        logic [4:0] irq_mask;
        logic ack;
        logic [31:0] rdata;
    } dch_regs_s;
endpackage

/* src/dch_cut_handshake.sv */
// Discrete handshake between the cutting supply and its motion controller
`timescale 1ns/100ps
`include "dch_regs.svh"

module dch_cut_handshake (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Controller inputs, asynchronous pins
    input wire logic remote_enable_i,
    input wire logic start_i,
    input wire logic pierce_hold_i,
    // Arc delay two-way pin
    input wire logic arc_delay_i,
    output logic arc_delay_o,
    output logic arc_delay_oe_o,
    // Supply internal conditions
    input wire logic arc_transfer_i,
    input wire logic pierce_detect_i,
    input wire logic alert_i,
    input wire logic error_i,
    input wire logic failure_i,
    input wire logic ohmic_contact_i,
    // Supply actuators
    output logic power_en_o,
    output logic gas_preflow_o,
    output logic shield_preflow_o,
    output logic arc_fire_o,
    // Controller outputs
    output logic ready_o,
    output logic arc_xfer_o,
    output logic pierce_thru_o,
    output logic fault_o,
    output logic shield_contact_o,
    // Interrupt
    output logic irq_o
);
    import dch_pkg::*;

    dch_regs_s q;
    dch_regs_s d;
    logic fault_any;
    logic acc;
    logic commit;
    logic go_ok;
    logic [`DCH_EV_W-1:0] ev;
    logic [`DCH_EV_W-1:0] clr;
    logic [31:0] pf_merge;

    // Merge write data into a register under byte enables
    function automatic logic [31:0] apply_sel(input logic [31:0] old_v,
            input logic [31:0] new_v, input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    assign fault_any = alert_i | error_i | failure_i;
    assign acc = wb_cyc_i & wb_stb_i & ~q.ack;
    assign commit = wb_cyc_i & wb_stb_i & wb_we_i & q.ack;
    assign go_ok = q.en_s2 & q.start_s2 & ~q.fault;
    assign pf_merge = apply_sel({16'h0000, q.pf_time}, wb_dat_i, wb_sel_i);

    always_comb begin
        d = q;
        ev = '0;
        clr = '0;
        // Input synchronisers
        d.en_s1 = remote_enable_i;
        d.en_s2 = q.en_s1;
        d.start_s1 = start_i;
        d.start_s2 = q.start_s1;
        d.delay_s1 = arc_delay_i;
        d.delay_s2 = q.delay_s1;
        d.hold_s1 = pierce_hold_i;
        d.hold_s2 = q.hold_s1;
        // Power follows remote enable
        d.power = q.en_s2;
        d.fault = fault_any;
        d.contact = ohmic_contact_i;
        d.shield = q.en_s2 & q.hold_s2;
        // Sequencer
        if (!q.en_s2) begin
            d.state = ST_OFF;
            d.pf_cnt = '0;
        end else begin
            case (q.state)
                ST_OFF: begin
                    d.state = ST_READY;
                end
                ST_READY: begin
                    if (go_ok) begin
                        d.state = ST_PREFLOW;
                        d.pf_cnt = q.pf_time;
                    end
                end
                ST_PREFLOW: begin
                    if (!go_ok) begin
                        d.state = ST_READY;
                    end else if (q.pf_cnt != '0) begin
                        d.pf_cnt = q.pf_cnt - `DCH_PF_ONE;
                    end else if (!q.delay_s2) begin
                        d.state = ST_FIRE;
                    end
                end
                ST_FIRE: begin
                    if (!go_ok) begin
                        d.state = ST_READY;
                    end else if (arc_transfer_i) begin
                        d.state = ST_CUT;
                    end
                end
                ST_CUT: begin
                    if (!go_ok) begin
                        d.state = ST_READY;
                    end
                end
                default: begin
                    d.state = ST_OFF;
                end
            endcase
        end
        d.xfer = (d.state == ST_CUT);
        d.pierce = (d.state == ST_CUT) & (q.pierce | pierce_detect_i);
        d.ready = (d.state == ST_READY) & q.en_s2 & ~d.fault;
        // Events
        ev[`DCH_EV_XFER] = d.xfer & ~q.xfer;
        ev[`DCH_EV_PIERCE] = d.pierce & ~q.pierce;
        ev[`DCH_EV_FAULT] = d.fault & ~q.fault;
        ev[`DCH_EV_EN_LOST] = q.power & ~q.en_s2;
        ev[`DCH_EV_READY] = d.ready & ~q.ready;
        // Register writes at the acknowledging edge
        if (commit) begin
            case (wb_adr_i)
                `DCH_OFF_CTRL: begin
                    if (wb_sel_i[0]) begin
                        d.dly_out = wb_dat_i[`DCH_CTRL_DLY_OUT];
                        d.dly_oe = wb_dat_i[`DCH_CTRL_DLY_OE];
                    end
                end
                `DCH_OFF_IRQ_STAT: begin
                    if (wb_sel_i[0]) begin
                        clr = wb_dat_i[`DCH_EV_W-1:0];
                    end
                end
                `DCH_OFF_IRQ_MASK: begin
                    if (wb_sel_i[0]) begin
                        d.irq_mask = wb_dat_i[`DCH_EV_W-1:0];
                    end
                end
                `DCH_OFF_PF_TIME: begin
                    d.pf_time = pf_merge[`DCH_PF_W-1:0];
                end
                default: begin
                end
            endcase
        end
        // Set wins over clear
        d.irq_stat = (q.irq_stat & ~clr) | ev;
        // Bus answer
        d.ack = acc;
        d.rdata = '0;
        if (acc && !wb_we_i) begin
            case (wb_adr_i)
                `DCH_OFF_CTRL: begin
                    d.rdata[`DCH_CTRL_DLY_OUT] = q.dly_out;
                    d.rdata[`DCH_CTRL_DLY_OE] = q.dly_oe;
                end
                `DCH_OFF_STATUS: begin
                    d.rdata[7:0] = {q.en_s2, q.start_s2, q.delay_s2, q.hold_s2,
                        q.fault, q.xfer, q.pierce, q.ready};
                    d.rdata[`DCH_ST_STATE_LSB +: 3] = q.state;
                end
                `DCH_OFF_IRQ_STAT: begin
                    d.rdata[`DCH_EV_W-1:0] = q.irq_stat;
                end
                `DCH_OFF_IRQ_MASK: begin
                    d.rdata[`DCH_EV_W-1:0] = q.irq_mask;
                end
                `DCH_OFF_PF_TIME: begin
                    d.rdata[`DCH_PF_W-1:0] = q.pf_time;
                end
                default: begin
                    d.rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
            q.pf_time <= `DCH_PF_TIME_RST;
        end else begin
            q <= d;
        end
    end

    // Outputs
    assign wb_ack_o = q.ack;
    assign wb_dat_o = q.rdata;
    assign power_en_o = q.power;
    assign gas_preflow_o = (q.state == ST_PREFLOW);
    assign shield_preflow_o = q.shield;
    assign arc_fire_o = (q.state == ST_FIRE) | (q.state == ST_CUT);
    assign ready_o = q.ready;
    assign arc_xfer_o = q.xfer;
    assign pierce_thru_o = q.pierce;
    assign fault_o = q.fault;
    assign shield_contact_o = q.contact;
    assign arc_delay_o = q.dly_out;
    assign arc_delay_oe_o = q.dly_oe;
    assign irq_o = |(q.irq_stat & q.irq_mask);

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_power_follows;
        (q.en_s2 != $past(q.en_s2)) |=> (power_en_o == $past(q.en_s2));
    endproperty
    a_power_follows: assert property (p_power_follows)
        else $error("power enable does not follow remote enable");

    property p_start_preflow;
        (q.state == ST_READY) && go_ok |=> gas_preflow_o ##1 gas_preflow_o || !go_ok;
    endproperty
    a_start_preflow: assert property (p_start_preflow)
        else $error("start did not enter preflow");

    property p_fire_after;
        (q.state == ST_PREFLOW) && go_ok && (q.pf_cnt == '0) && !q.delay_s2
            |=> arc_fire_o && !gas_preflow_o;
    endproperty
    a_fire_after: assert property (p_fire_after)
        else $error("preflow did not go on to fire");

    property p_delay_holds;
        (q.state == ST_PREFLOW) && go_ok && q.delay_s2 |=> !arc_fire_o;
    endproperty
    a_delay_holds: assert property (p_delay_holds)
        else $error("arc fired while delay asserted");

    property p_xfer;
        (q.state == ST_FIRE) && go_ok && arc_transfer_i |=> arc_xfer_o && arc_fire_o;
    endproperty
    a_xfer: assert property (p_xfer)
        else $error("arc transfer not reported");

    property p_xfer_only_cut;
        arc_xfer_o |-> (q.state == ST_CUT) && $past(arc_fire_o);
    endproperty
    a_xfer_only_cut: assert property (p_xfer_only_cut)
        else $error("arc transfer reported without firing");

    property p_shield;
        q.en_s2 && q.hold_s2 |=> shield_preflow_o;
    endproperty
    a_shield: assert property (p_shield)
        else $error("shield preflow ended while hold asserted");

    property p_shield_end;
        !q.hold_s2 |=> !shield_preflow_o;
    endproperty
    a_shield_end: assert property (p_shield_end)
        else $error("shield preflow outlived hold");

    property p_fault;
        (fault_any |=> fault_o) and (!fault_any |=> !fault_o);
    endproperty
    a_fault: assert property (p_fault)
        else $error("fault output missed a condition");

    property p_ready_start;
        ready_o && go_ok |=> (q.state == ST_PREFLOW) && !ready_o;
    endproperty
    a_ready_start: assert property (p_ready_start)
        else $error("ready supply did not accept start");

    property p_pierce;
        (q.state == ST_CUT) && go_ok && pierce_detect_i |=> pierce_thru_o;
    endproperty
    a_pierce: assert property (p_pierce)
        else $error("pierce-through not reported");

    property p_oe_reset;
        $past(rst_i) |-> !arc_delay_oe_o;
    endproperty
    a_oe_reset: assert property (@(posedge clk_i) p_oe_reset)
        else $error("arc delay pin driven after reset");

    property p_contact;
        ohmic_contact_i |=> shield_contact_o;
    endproperty
    a_contact: assert property (p_contact)
        else $error("shield contact not presented");

    property p_disabled;
        !q.en_s2 |=> !ready_o && (q.state == ST_OFF);
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("disabled supply ready or sequencing");

    property p_ack_once;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once)
        else $error("acknowledge held longer than one cycle");

    c_cut: cover property ((q.state == ST_FIRE) ##1 (q.state == ST_CUT));
    c_delay: cover property ((q.state == ST_PREFLOW && q.delay_s2)[*4] ##1 arc_fire_o);
    c_pierce: cover property ($rose(pierce_thru_o));
    c_irq: cover property ($rose(irq_o));

endmodule // dch_cut_handshake

/* tb/dch_ctrl_model.sv */
// Behavioural motion controller that drives the discrete pins
`timescale 1ns/100ps
module dch_ctrl_model #(
    parameter int PIERCE_DLY = 4
) (
    // Clock
    input wire logic clk_i,
    // Requests from the bench
    input wire logic en_req_i,
    input wire logic run_req_i,
    input wire logic delay_req_i,
    input wire logic hold_req_i,
    input wire logic xfer_i,
    // Pins toward the supply
    output logic remote_enable_o,
    output logic start_o,
    output logic arc_delay_o,
    output logic pierce_hold_o,
    output logic motion_o
);
    int dly_cnt = 0;
    always @(posedge clk_i) begin
        remote_enable_o <= en_req_i;
        start_o <= run_req_i;
        // Delay rises only with start, falls to fire
        arc_delay_o <= run_req_i && delay_req_i && (arc_delay_o || !start_o);
        // Hold rises only with start, falls after fire, before transfer
        pierce_hold_o <= run_req_i && hold_req_i && (pierce_hold_o || !start_o);
        // Motion waits out the pierce delay; fault not used
        dly_cnt <= xfer_i ? dly_cnt + 1 : 0;
        motion_o <= xfer_i && (dly_cnt >= PIERCE_DLY);
    end
endmodule // dch_ctrl_model

/* tb/tb.sv */
// Self-checking bench for the discrete cut handshake
`timescale 1ns/100ps
`include "dch_regs.svh"
module tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat_w = 32'h0;
    logic [3:0] sel = 4'hf;
    logic en_req = 1'b0, run_req = 1'b0, dly_req = 1'b0, hold_req = 1'b0;
    logic xfer_in = 1'b0, pierce_in = 1'b0, contact = 1'b0;
    logic [2:0] flt = 3'b000;
    logic [31:0] seed = 32'h3a0a4fa8;
    int failures = 0;
    int total_checks = 0;
    wire logic [31:0] rdat;
    wire logic ack, en_pin, start_pin, hold_pin, mdl_dly, motion, dly_o, dly_oe;
    wire logic power, gas, shield, fire, ready, xfer, pthru, fault, scon, irq;
    wire logic dly_pin = dly_oe ? dly_o : mdl_dly;
    wire logic [9:0] obs = {irq, scon, shield, fire, gas, power, fault, pthru, xfer, ready};

    always #10 clk_i = ~clk_i;

    dch_ctrl_model u_dch_ctrl_model (.clk_i(clk_i), .en_req_i(en_req), .run_req_i(run_req),
        .delay_req_i(dly_req), .hold_req_i(hold_req), .xfer_i(xfer), .remote_enable_o(en_pin),
        .start_o(start_pin), .arc_delay_o(mdl_dly), .pierce_hold_o(hold_pin), .motion_o(motion));

    dch_cut_handshake u_dch_cut_handshake (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w),
        .wb_dat_o(rdat), .wb_ack_o(ack), .remote_enable_i(en_pin), .start_i(start_pin),
        .pierce_hold_i(hold_pin), .arc_delay_i(dly_pin), .arc_delay_o(dly_o),
        .arc_delay_oe_o(dly_oe), .arc_transfer_i(xfer_in), .pierce_detect_i(pierce_in),
        .alert_i(flt[0]), .error_i(flt[1]), .failure_i(flt[2]), .ohmic_contact_i(contact),
        .power_en_o(power), .gas_preflow_o(gas), .shield_preflow_o(shield),
        .arc_fire_o(fire), .ready_o(ready), .arc_xfer_o(xfer), .pierce_thru_o(pthru),
        .fault_o(fault), .shield_contact_o(scon), .irq_o(irq));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic close_out();
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50) begin
            failures++;
            close_out();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        wb(1'b1, a, d, r);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        wb(1'b0, a, 32'h0, r);
        chk(r, e);
    endtask

    task automatic wait_o(input int i, input logic v);
        int n;
        n = 0;
        while (obs[i] !== v && n < 100) begin
            @(posedge clk_i);
            n++;
        end
        chk({31'h0, obs[i]}, {31'h0, v});
        if (n >= 100) close_out();
    endtask

    initial begin
        logic [31:0] r;
        int pf;
        int n;
        repeat (6) @(posedge clk_i);
        chk({22'h0, obs}, 32'h0);
        rst_i <= 1'b0;
        // Register file, unmapped place, arc delay drive
        rd(`DCH_OFF_PF_TIME, {16'h0, `DCH_PF_TIME_RST});
        rd(`DCH_OFF_CTRL, 32'h0);
        wr(8'h40, 32'hffffffff);
        rd(8'h40, 32'h0);
        r = rnd();
        pf = 1 + int'(r[1:0]);
        wr(`DCH_OFF_PF_TIME, 32'(pf));
        rd(`DCH_OFF_PF_TIME, 32'(pf));
        wr(`DCH_OFF_CTRL, 32'h3);
        repeat (3) @(posedge clk_i);
        chk({30'h0, dly_oe, dly_o}, 32'h3);
        wr(`DCH_OFF_CTRL, 32'h0);
        $display("test regs done");
        // Enable, delayed and held start, transfer, pierce
        en_req <= 1'b1;
        wait_o(4, 1'b1);
        wait_o(0, 1'b1);
        dly_req <= 1'b1;
        hold_req <= 1'b1;
        run_req <= 1'b1;
        wait_o(5, 1'b1);
        wait_o(0, 1'b0);
        repeat (pf + 20) @(posedge clk_i);
        chk({30'h0, gas, fire}, 32'h2);
        chk({31'h0, shield}, 32'h1);
        dly_req <= 1'b0;
        wait_o(6, 1'b1);
        chk({31'h0, shield}, 32'h1);
        hold_req <= 1'b0;
        wait_o(7, 1'b0);
        xfer_in <= 1'b1;
        wait_o(1, 1'b1);
        chk({31'h0, motion}, 32'h0);
        pierce_in <= 1'b1;
        wait_o(2, 1'b1);
        repeat (4) @(posedge clk_i);
        chk({31'h0, motion}, 32'h1);
        run_req <= 1'b0;
        xfer_in <= 1'b0;
        pierce_in <= 1'b0;
        wait_o(0, 1'b1);
        chk({31'h0, pthru}, 32'h0);
        $display("test cut done");
        // Plain start, preflow length from pf_time
        run_req <= 1'b1;
        wait_o(5, 1'b1);
        n = 0;
        while (gas === 1'b1 && n < 100) begin
            @(posedge clk_i);
            n++;
        end
        chk(32'(n), 32'(pf + 1));
        run_req <= 1'b0;
        wait_o(0, 1'b1);
        $display("test preflow done");
        // Each fault source, then interrupt mask and clear
        wr(`DCH_OFF_IRQ_MASK, 32'h0);
        wr(`DCH_OFF_IRQ_STAT, 32'h1f);
        rd(`DCH_OFF_IRQ_STAT, 32'h0);
        for (int k = 0; k < 3; k++) begin
            flt <= 3'b001 << k;
            wait_o(3, 1'b1);
            flt <= 3'b000;
            wait_o(3, 1'b0);
        end
        chk({31'h0, irq}, 32'h0);
        wr(`DCH_OFF_IRQ_MASK, 32'h4);
        wait_o(9, 1'b1);
        wb(1'b0, `DCH_OFF_IRQ_STAT, 32'h0, r);
        chk({31'h0, r[`DCH_EV_FAULT]}, 32'h1);
        wr(`DCH_OFF_IRQ_STAT, 32'h4);
        wait_o(9, 1'b0);
        $display("test fault done");
        // Random contact pattern
        repeat (6) begin
            r = rnd();
            contact <= r[0];
            repeat (3) @(posedge clk_i);
            chk({31'h0, scon}, {31'h0, r[0]});
        end
        $display("test contact done");
        // Enable open: no ready, start ignored
        en_req <= 1'b0;
        wait_o(4, 1'b0);
        wait_o(0, 1'b0);
        run_req <= 1'b1;
        repeat (20) @(posedge clk_i);
        chk({30'h0, gas, ready}, 32'h0);
        run_req <= 1'b0;
        $display("test disable done");
        close_out();
    end
endmodule // tb
